// *** hdl/dsc_pkg.sv ***
// Package for the D/A sequencer control and status block.
// Assumes a 32-bit APB register bus and a single 10 MHz clock.
package dsc_pkg;
	// ----------------------------------------
	// Register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [11:0] DSC_CONTROL_OFFSET = 12'h2E8; // Sequencer control
	localparam logic [11:0] DSC_STATUS_OFFSET = 12'h2EC; // Sequencer status
	localparam logic [11:0] DSC_BUFLEN_OFFSET = 12'h2F8; // Buffer length (validate)
	localparam logic [11:0] DSC_IRQ_STATUS_OFFSET = 12'h300; // Sticky events
	localparam logic [11:0] DSC_IRQ_MASK_OFFSET = 12'h304; // Event mask
	// ----------------------------------------
	// Control field positions
	// ----------------------------------------
	localparam int DSC_CTL_OU_RESET_BIT = 1; // Output unit reset, self clearing
	localparam int DSC_CTL_MODE_BIT = 2; // 0 normal, 1 frame
	localparam int DSC_CTL_START_BIT = 3; // Normal run start, self clearing
	localparam int DSC_CTL_CLR_PRELOAD_BIT = 4; // Clear preload, self clearing
	localparam int DSC_CTL_CLK_SEL_BIT = 5; // Conversion clock select
	localparam int DSC_CTL_OU_ENABLE_BIT = 0; // Output unit enable
	localparam int DSC_CTL_FETCH_ENABLE_BIT = 16; // Fetch engine enable
	// ----------------------------------------
	// Status field positions
	// ----------------------------------------
	localparam int DSC_ST_PRELOADED_BIT = 1; // DACs preloaded
	localparam int DSC_ST_ACTIVE_BIT = 2; // Conversion run active
	localparam int DSC_ST_IDLE_BIT = 16; // Fetch engine idle
	localparam int DSC_ST_BUSY_BIT = 17; // Fetch engine busy
	localparam int DSC_ST_ERROR_BIT = 18; // Fetch engine error
	localparam int DSC_ST_DONE_BIT = 20; // Buffer fetch done
	// ----------------------------------------
	// Interrupt event layout and reset values
	// ----------------------------------------
	localparam int DSC_EVT_WIDTH = 3; // Done, error, run end
	localparam logic [2:0] DSC_MASK_RESET = 3'h0; // All events masked
	localparam logic [31:0] DSC_CONTROL_RESET = 32'h0000_0000; // Control reset value
	// Fetch engine states
	typedef enum logic [2:0] {
		DSC_FE_IDLE = 3'b001,
		DSC_FE_BUSY = 3'b010,
		DSC_FE_ERROR = 3'b100
	} dsc_fetch_state_type;
endpackage

// *** hdl/dsc_edge_sync.sv ***
// Two-flop synchroniser with rising-edge pulse output.
// Assumes a pin input from outside the CLOCK domain.
`timescale 1ns/10ps
module dsc_edge_sync (
	input wire logic clk,
	input wire logic rst,
	input wire logic async_in,
	output logic level_out,
	output logic rise_out
);
	logic meta_r; // First stage, read only by second stage
	logic sync_r; // Second stage
	logic prev_r; // Delayed copy for edge detect
	// Synchroniser and edge history
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_r <= 1'b0;
			sync_r <= 1'b0;
			prev_r <= 1'b0;
		end else begin
			meta_r <= async_in;
			sync_r <= meta_r;
			prev_r <= sync_r;
		end
	end
	assign level_out = sync_r;
	assign rise_out = sync_r & ~prev_r;
endmodule

// *** hdl/dsc_fetch_engine.sv ***
// Fetch engine status tracker: idle, busy, error and done.
// Assumes transfer start, end and abort strobes from the PCI master on CLOCK.
`timescale 1ns/10ps
module dsc_fetch_engine (
	input wire logic clk,
	input wire logic rst,
	input wire logic enable,
	input wire logic xfer_start,
	input wire logic xfer_end,
	input wire logic buffer_end,
	input wire logic bus_abort,
	input wire logic validate_wr,
	output logic busy,
	output logic error,
	output logic idle,
	output logic done,
	output logic run_ok
);
	dsc_pkg::dsc_fetch_state_type state_r; // Engine state
	logic done_r; // Buffer fetch done flag
	// --------------------------------
	// Engine state machine
	// --------------------------------
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r <= dsc_pkg::DSC_FE_IDLE;
		end else begin
			case (state_r)
				dsc_pkg::DSC_FE_IDLE: begin
					if (enable && xfer_start) begin
						state_r <= dsc_pkg::DSC_FE_BUSY;
					end
				end
				dsc_pkg::DSC_FE_BUSY: begin
					// Abort stops the engine; a disable lets the transfer finish
					if (bus_abort) begin
						state_r <= dsc_pkg::DSC_FE_ERROR;
					end else if (xfer_end) begin
						state_r <= dsc_pkg::DSC_FE_IDLE;
					end
				end
				dsc_pkg::DSC_FE_ERROR: begin
					if (!enable) begin
						state_r <= dsc_pkg::DSC_FE_IDLE;
					end
				end
				default: begin
					state_r <= dsc_pkg::DSC_FE_IDLE;
				end
			endcase
		end
	end
	// Done flag: set wins over the validate clear
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			done_r <= 1'b0;
		end else if (state_r == dsc_pkg::DSC_FE_BUSY && xfer_end && buffer_end && !bus_abort) begin
			done_r <= 1'b1;
		end else if (validate_wr && state_r == dsc_pkg::DSC_FE_IDLE) begin
			done_r <= 1'b0;
		end
	end
	assign busy = (state_r == dsc_pkg::DSC_FE_BUSY);
	assign error = (state_r == dsc_pkg::DSC_FE_ERROR);
	assign idle = (state_r == dsc_pkg::DSC_FE_IDLE);
	assign done = done_r;
	assign run_ok = enable && (state_r != dsc_pkg::DSC_FE_ERROR);
	// Abort while busy must land in the error state next cycle
	abort_error_a: assert property (@(posedge clk) disable iff (rst)
		(busy && bus_abort) |=> error) else $error("abort did not enter error");
	// Error stays while enabled
	error_hold_a: assert property (@(posedge clk) disable iff (rst)
		(error && enable) |=> error) else $error("error left while enabled");
endmodule

// *** hdl/dsc_top.sv ***
// Top of the D/A sequencer control and status block with APB slave.
// Assumes APB master on CLOCK; conversion clocks and frame trigger are pins.
//
// Operation
// - Select bit picks conversion clock one/two
// - Clear preload marks DACs unloaded, self clears
// - Reload DACs automatically when FIFO has data
// - Start begins normal run if unit enabled
// - Mode bit: zero normal, one frame
// - Normal run converts on next clock event
// - Frame trigger starts conversions on next event
// - Output unit reset keeps registers, self clears
// - Done set when whole buffer fetched
// - Done cleared by length write while idle
// - Error state entered on bus aborts
// - Engine stops on error until disabled
// - Error clears when engine disabled
// - Busy shows active transfer
// - Disable finishes transfer, then engine resets
// - Preloaded flag clears on conversion or clear
`timescale 1ns/10ps
module dsc_top (
	input wire logic CLOCK,
	input wire logic RST,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [11:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	input wire logic CONV_CLK1,
	input wire logic CONV_CLK2,
	input wire logic FRAME_TRIGGER,
	input wire logic FIFO_HAS_DATA,
	input wire logic [15:0] RUN_LENGTH,
	input wire logic XFER_START,
	input wire logic XFER_END,
	input wire logic BUFFER_END,
	input wire logic BUS_ABORT,
	output logic PRELOAD_REQ,
	input wire logic PRELOAD_ACK,
	output logic CONV_PULSE,
	output logic OU_RESET,
	output logic FETCH_ENABLE,
	output logic FETCH_RUN_OK,
	output logic IRQ
);
	// ----------------------------------------
	// Declarations
	// ----------------------------------------
	logic [31:0] control_r; // Stored control bits
	logic start_r; // Normal start pulse
	logic clr_preload_r; // Clear preload pulse
	logic ou_reset_r; // Output unit reset pulse
	logic preloaded_r; // All DACs preloaded
	logic active_r; // Conversion run active
	logic armed_r; // Waiting for next clock event
	logic [15:0] count_r; // Conversions left in run
	logic [2:0] irq_status_r; // Sticky events
	logic [2:0] irq_mask_r; // Event mask
	logic [2:0] events; // Event pulses this cycle
	logic [31:0] rdata_nxt; // Read mux
	logic [31:0] prdata_r; // Registered read data
	logic wr_en; // APB write access phase
	logic rd_en; // APB read setup phase
	logic mapped; // Address decodes
	logic clk1_lvl, clk1_rise; // Conversion clock one
	logic clk2_lvl, clk2_rise; // Conversion clock two
	logic trig_lvl, trig_rise; // Frame trigger
	logic conv_event; // Selected clock event
	logic fe_busy, fe_error, fe_idle, fe_done; // Fetch engine status
	logic fe_done_d; // Done history for event
	logic fe_error_d; // Error history for event
	logic run_end; // Run finished this cycle
	logic ou_enable; // Output unit enable
	logic frame_mode; // Mode select
	// ----------------------------------------
	// Pin synchronisers
	// ----------------------------------------
	dsc_edge_sync u_clk1 (.clk(CLOCK), .rst(RST), .async_in(CONV_CLK1),
		.level_out(clk1_lvl), .rise_out(clk1_rise));
	dsc_edge_sync u_clk2 (.clk(CLOCK), .rst(RST), .async_in(CONV_CLK2),
		.level_out(clk2_lvl), .rise_out(clk2_rise));
	dsc_edge_sync u_trig (.clk(CLOCK), .rst(RST), .async_in(FRAME_TRIGGER),
		.level_out(trig_lvl), .rise_out(trig_rise));
	// Conversion clock chosen by select bit
	assign conv_event = control_r[dsc_pkg::DSC_CTL_CLK_SEL_BIT] ? clk2_rise : clk1_rise;
	assign ou_enable = control_r[dsc_pkg::DSC_CTL_OU_ENABLE_BIT];
	assign frame_mode = control_r[dsc_pkg::DSC_CTL_MODE_BIT];
	// ----------------------------------------
	// APB decode
	// ----------------------------------------
	assign wr_en = PSEL && PENABLE && PWRITE;
	assign rd_en = PSEL && !PENABLE && !PWRITE;
	assign mapped = (PADDR == dsc_pkg::DSC_CONTROL_OFFSET) ||
		(PADDR == dsc_pkg::DSC_STATUS_OFFSET) ||
		(PADDR == dsc_pkg::DSC_BUFLEN_OFFSET) ||
		(PADDR == dsc_pkg::DSC_IRQ_STATUS_OFFSET) ||
		(PADDR == dsc_pkg::DSC_IRQ_MASK_OFFSET);
	assign PREADY = PSEL && PENABLE; // Zero wait states
	assign PSLVERR = PSEL && PENABLE && !mapped;
	assign PRDATA = prdata_r;
	// Stored control bits; command bits never stored
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			control_r <= dsc_pkg::DSC_CONTROL_RESET;
		end else if (wr_en && PADDR == dsc_pkg::DSC_CONTROL_OFFSET) begin
			control_r <= PWDATA & 32'h0001_0025;
		end
	end
	// Self-clearing command pulses
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			start_r <= 1'b0;
			clr_preload_r <= 1'b0;
			ou_reset_r <= 1'b0;
		end else begin
			start_r <= wr_en && PADDR == dsc_pkg::DSC_CONTROL_OFFSET &&
				PWDATA[dsc_pkg::DSC_CTL_START_BIT];
			clr_preload_r <= wr_en && PADDR == dsc_pkg::DSC_CONTROL_OFFSET &&
				PWDATA[dsc_pkg::DSC_CTL_CLR_PRELOAD_BIT];
			ou_reset_r <= wr_en && PADDR == dsc_pkg::DSC_CONTROL_OFFSET &&
				PWDATA[dsc_pkg::DSC_CTL_OU_RESET_BIT];
		end
	end
	// ----------------------------------------
	// Preload tracking
	// ----------------------------------------
	// Request reload while unloaded and FIFO holds data
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			preloaded_r <= 1'b0;
		end else if (clr_preload_r || CONV_PULSE || ou_reset_r) begin
			preloaded_r <= 1'b0;
		end else if (PRELOAD_ACK) begin
			preloaded_r <= 1'b1;
		end
	end
	assign PRELOAD_REQ = !preloaded_r && FIFO_HAS_DATA && !clr_preload_r;
	// ----------------------------------------
	// Conversion run control
	// ----------------------------------------
	// Arm on start or trigger, convert on the next clock event
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			armed_r <= 1'b0;
			active_r <= 1'b0;
			count_r <= 16'h0000;
			CONV_PULSE <= 1'b0;
		end else if (ou_reset_r || !ou_enable) begin
			armed_r <= 1'b0;
			active_r <= 1'b0;
			count_r <= 16'h0000;
			CONV_PULSE <= 1'b0;
		end else begin
			CONV_PULSE <= 1'b0;
			if (!active_r && ((!frame_mode && start_r) || (frame_mode && trig_rise))) begin
				active_r <= 1'b1;
				armed_r <= 1'b1;
				count_r <= RUN_LENGTH;
			end else if (active_r && conv_event) begin
				// First and later conversions follow clock events
				CONV_PULSE <= 1'b1;
				armed_r <= 1'b0;
				if (count_r <= 16'h0001) begin
					active_r <= 1'b0;
					count_r <= 16'h0000;
				end else begin
					count_r <= count_r - 16'h0001;
				end
			end
		end
	end
	assign run_end = CONV_PULSE && !active_r;
	assign OU_RESET = ou_reset_r;
	// ----------------------------------------
	// Fetch engine
	// ----------------------------------------
	dsc_fetch_engine u_fetch (
		.clk(CLOCK),
		.rst(RST),
		.enable(control_r[dsc_pkg::DSC_CTL_FETCH_ENABLE_BIT]),
		.xfer_start(XFER_START),
		.xfer_end(XFER_END),
		.buffer_end(BUFFER_END),
		.bus_abort(BUS_ABORT),
		.validate_wr(wr_en && PADDR == dsc_pkg::DSC_BUFLEN_OFFSET),
		.busy(fe_busy),
		.error(fe_error),
		.idle(fe_idle),
		.done(fe_done),
		.run_ok(FETCH_RUN_OK)
	);
	assign FETCH_ENABLE = control_r[dsc_pkg::DSC_CTL_FETCH_ENABLE_BIT];
	// ----------------------------------------
	// Interrupts
	// ----------------------------------------
	// Event edges: done, error, run end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			fe_done_d <= 1'b0;
			fe_error_d <= 1'b0;
		end else begin
			fe_done_d <= fe_done;
			fe_error_d <= fe_error;
		end
	end
	assign events = {run_end, fe_error && !fe_error_d, fe_done && !fe_done_d};
	// Sticky status cleared by read; a new event wins
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			irq_status_r <= 3'h0;
		end else if (rd_en && PADDR == dsc_pkg::DSC_IRQ_STATUS_OFFSET) begin
			irq_status_r <= events;
		end else begin
			irq_status_r <= irq_status_r | events;
		end
	end
	// Mask register
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			irq_mask_r <= dsc_pkg::DSC_MASK_RESET;
		end else if (wr_en && PADDR == dsc_pkg::DSC_IRQ_MASK_OFFSET) begin
			irq_mask_r <= PWDATA[2:0];
		end
	end
	assign IRQ = |(irq_status_r & irq_mask_r);
	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// Read mux, sampled in setup phase
	always_comb begin
		rdata_nxt = 32'h0000_0000;
		case (PADDR)
			dsc_pkg::DSC_CONTROL_OFFSET: rdata_nxt = control_r;
			dsc_pkg::DSC_STATUS_OFFSET: begin
				rdata_nxt[dsc_pkg::DSC_ST_PRELOADED_BIT] = preloaded_r;
				rdata_nxt[dsc_pkg::DSC_ST_ACTIVE_BIT] = active_r;
				rdata_nxt[dsc_pkg::DSC_ST_IDLE_BIT] = fe_idle;
				rdata_nxt[dsc_pkg::DSC_ST_BUSY_BIT] = fe_busy;
				rdata_nxt[dsc_pkg::DSC_ST_ERROR_BIT] = fe_error;
				rdata_nxt[dsc_pkg::DSC_ST_DONE_BIT] = fe_done;
			end
			dsc_pkg::DSC_IRQ_STATUS_OFFSET: rdata_nxt = {29'h0, irq_status_r};
			dsc_pkg::DSC_IRQ_MASK_OFFSET: rdata_nxt = {29'h0, irq_mask_r};
			default: rdata_nxt = 32'h0000_0000;
		endcase
	end
	always_ff @(posedge CLOCK or posedge RST) begin
		if (RST) begin
			prdata_r <= 32'h0000_0000;
		end else if (rd_en) begin
			prdata_r <= rdata_nxt;
		end
	end
	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	clock_select_a: assert property (@(posedge CLOCK) disable iff (RST)
		(active_r && !ou_reset_r && ou_enable && clk2_rise && !clk1_rise && !control_r[5])
		|=> !CONV_PULSE) else $error("wrong clock used");
	clear_preload_a: assert property (@(posedge CLOCK) disable iff (RST)
		clr_preload_r |=> !preloaded_r) else $error("preload not cleared");
	reload_req_a: assert property (@(posedge CLOCK) disable iff (RST)
		(!preloaded_r && FIFO_HAS_DATA && !clr_preload_r) |-> PRELOAD_REQ)
		else $error("no reload request");
	start_run_a: assert property (@(posedge CLOCK) disable iff (RST)
		(start_r && ou_enable && !frame_mode && !active_r && !ou_reset_r) |=> active_r)
		else $error("start ignored");
	start_self_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		start_r |=> !start_r || $past(wr_en)) else $error("start stuck");
	frame_trigger_a: assert property (@(posedge CLOCK) disable iff (RST)
		(trig_rise && frame_mode && ou_enable && !active_r && !ou_reset_r) |=> active_r)
		else $error("trigger ignored");
	normal_convert_a: assert property (@(posedge CLOCK) disable iff (RST)
		(active_r && conv_event && ou_enable && !ou_reset_r) |=> CONV_PULSE)
		else $error("no conversion on event");
	unit_reset_a: assert property (@(posedge CLOCK) disable iff (RST)
		ou_reset_r |=> (!active_r && $stable(control_r))) else $error("reset bad");
	preload_conv_a: assert property (@(posedge CLOCK) disable iff (RST)
		CONV_PULSE |=> !preloaded_r) else $error("preload kept");
	idle_flag_a: assert property (@(posedge CLOCK) disable iff (RST)
		fe_idle == (!fe_busy && !fe_error)) else $error("idle wrong");
	error_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		(fe_error && !FETCH_ENABLE) |=> !fe_error) else $error("error kept");
	disable_finish_a: assert property (@(posedge CLOCK) disable iff (RST)
		(fe_busy && !FETCH_ENABLE && !XFER_END && !BUS_ABORT) |=> fe_busy)
		else $error("transfer cut");
	done_clear_a: assert property (@(posedge CLOCK) disable iff (RST)
		(fe_done && fe_idle && wr_en && PADDR == dsc_pkg::DSC_BUFLEN_OFFSET) |=> !fe_done)
		else $error("done kept");
	run_cover_c: cover property (@(posedge CLOCK) disable iff (RST) start_r ##[1:50] run_end);
	frame_cover_c: cover property (@(posedge CLOCK) disable iff (RST) frame_mode && trig_rise);
	abort_cover_c: cover property (@(posedge CLOCK) disable iff (RST) fe_busy ##1 fe_error);
	irq_cover_c: cover property (@(posedge CLOCK) disable iff (RST) $rose(IRQ));
endmodule

// *** verif/dsc_far_model.sv ***
// Far side of the sequencer: conversion clocks, frame trigger, FIFO level,
// PCI master strobes and the DAC preload handshake.
// Assumes the bench sets the control variables through this instance.
`timescale 1ns/10ps
module dsc_far_model (
	input wire logic clk,
	input wire logic preload_req,
	input wire logic run1,
	input wire logic run2,
	input wire logic fifo,
	output logic conv_clk1,
	output logic conv_clk2,
	output logic frame_trigger,
	output logic fifo_has_data,
	output logic xfer_start,
	output logic xfer_end,
	output logic buffer_end,
	output logic bus_abort,
	output logic preload_ack
);
	// ----------------------------------------
	// Controls set by the bench
	// ----------------------------------------
	int ack_dly = 2; // Cycles before a preload completes
	int ack_cnt = 0; // Preload wait counter
	logic [4:0] strb = 5'h00; // Trigger, abort, buffer end, end, start
	assign {frame_trigger, bus_abort, buffer_end, xfer_end, xfer_start} = strb;
	assign fifo_has_data = fifo;
	// ----------------------------------------
	// Conversion clocks, still when stopped
	// ----------------------------------------
	initial begin
		conv_clk1 = 1'b0;
		forever #500 conv_clk1 = run1 ? ~conv_clk1 : 1'b0;
	end
	initial begin
		conv_clk2 = 1'b0;
		forever #700 conv_clk2 = run2 ? ~conv_clk2 : 1'b0;
	end
	// ----------------------------------------
	// DACs finish a preload after a delay
	// ----------------------------------------
	initial preload_ack = 1'b0;
	always @(posedge clk) begin
		if (!preload_req || preload_ack) begin
			ack_cnt <= 0;
			preload_ack <= 1'b0;
		end else if (ack_cnt >= ack_dly) begin
			preload_ack <= 1'b1;
		end else begin
			ack_cnt <= ack_cnt + 1;
		end
	end
	// One-cycle strobes; a trigger follows a clock one edge
	task automatic fire(input logic [4:0] m);
		if (m[4]) @(posedge conv_clk1);
		@(posedge clk);
		strb <= m;
		@(posedge clk);
		strb <= 5'h00;
	endtask
endmodule

// *** verif/tb.sv ***
// Self-checking bench for the sequencer control and status block.
// Assumes a zero-wait APB slave and the far-side model beside it.
`timescale 1ns/10ps
module tb;
	// ----------------------------------------
	// Signals and constants
	// ----------------------------------------
	localparam logic [11:0] A_CTL = dsc_pkg::DSC_CONTROL_OFFSET;
	localparam logic [11:0] A_ST = dsc_pkg::DSC_STATUS_OFFSET;
	localparam logic [11:0] A_BUF = dsc_pkg::DSC_BUFLEN_OFFSET;
	localparam logic [11:0] A_IRQ = dsc_pkg::DSC_IRQ_STATUS_OFFSET;
	localparam logic [11:0] A_MSK = dsc_pkg::DSC_IRQ_MASK_OFFSET;
	localparam logic [31:0] S_IDLE = 32'h1 << dsc_pkg::DSC_ST_IDLE_BIT;
	localparam logic [31:0] S_BUSY = 32'h1 << dsc_pkg::DSC_ST_BUSY_BIT;
	localparam logic [31:0] S_ERR = 32'h1 << dsc_pkg::DSC_ST_ERROR_BIT;
	localparam logic [31:0] S_DONE = 32'h1 << dsc_pkg::DSC_ST_DONE_BIT;
	localparam logic [31:0] S_PRLD = 32'h1 << dsc_pkg::DSC_ST_PRELOADED_BIT;
	logic clk, rst, psel, penable, pwrite, pready, pslverr, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic [15:0] run_len;
	logic c1, c2, ft, fifo, xs, xe, be, ab, preq, pack, conv, our, fen, fok, irq;
	logic r1 = 1'b0; // Conversion clock one running
	logic r2 = 1'b0; // Conversion clock two running
	logic ff = 1'b0; // FIFO holds data
	int mismatches = 0;
	int cmp_count = 0;
	int pulses = 0; // Conversion pulses seen
	int ou_cnt = 0; // Output unit reset pulses seen
	dsc_top DUT (.CLOCK(clk), .RST(rst), .PSEL(psel), .PENABLE(penable),
		.PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata),
		.PREADY(pready), .PSLVERR(pslverr), .CONV_CLK1(c1), .CONV_CLK2(c2),
		.FRAME_TRIGGER(ft), .FIFO_HAS_DATA(fifo), .RUN_LENGTH(run_len),
		.XFER_START(xs), .XFER_END(xe), .BUFFER_END(be), .BUS_ABORT(ab),
		.PRELOAD_REQ(preq), .PRELOAD_ACK(pack), .CONV_PULSE(conv),
		.OU_RESET(our), .FETCH_ENABLE(fen), .FETCH_RUN_OK(fok), .IRQ(irq));
	dsc_far_model u_far (.clk(clk), .preload_req(preq), .run1(r1), .run2(r2),
		.fifo(ff), .conv_clk1(c1),
		.conv_clk2(c2), .frame_trigger(ft), .fifo_has_data(fifo),
		.xfer_start(xs), .xfer_end(xe), .buffer_end(be), .bus_abort(ab),
		.preload_ack(pack));
	// ----------------------------------------
	// Clock, pulse counters and tasks
	// ----------------------------------------
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	always @(posedge clk) begin
		pulses += int'(conv);
		ou_cnt += int'(our);
	end
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] x);
		cmp_count++;
		if (seen !== x) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", nm, x, seen);
		end
	endtask
	// One APB transfer, entered just after a rising edge
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n;
		n = 0;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		// Idle edge so a following call never re-raises psel in this step
		@(posedge clk);
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
		repeat (2) @(posedge clk);
	endtask
	task automatic rd_chk(input string nm, input logic [11:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		check(nm, q, x);
	endtask
	// Write control, let the run play out, count conversions
	task automatic run_chk(input string nm, input logic [31:0] ctl, input int x);
		pulses = 0;
		wr(A_CTL, ctl);
		repeat (80) @(posedge clk);
		check(nm, 32'(pulses), 32'(x));
	endtask
	task automatic tally_and_finish;
		$display("compares %0d mismatches %0d", cmp_count, mismatches);
		if (mismatches == 0 && cmp_count > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// Cut a hang short
	initial begin
		#2000000;
		mismatches++;
		tally_and_finish;
	end
	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		{psel, penable, pwrite, paddr, pwdata} = '0;
		run_len = 16'h0003;
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		rd_chk("ctl reset", A_CTL, dsc_pkg::DSC_CONTROL_RESET);
		rd_chk("st reset", A_ST, S_IDLE);
		rd_chk("mask reset", A_MSK, 32'(dsc_pkg::DSC_MASK_RESET));
		apb(1'b0, 12'h2F0, 32'h0);
		check("unmapped err", 32'(e), 32'h1);
		check("unmapped data", q, 32'h0);
		wr(A_ST, 32'hFFFF_FFFF);
		rd_chk("st read only", A_ST, S_IDLE);
		// Self-clearing bits read back low; unit reset pulses once
		ou_cnt = 0;
		wr(A_CTL, 32'hFFFF_FFFF);
		rd_chk("ctl bits", A_CTL, 32'h0001_0025);
		check("ou pulse", 32'(ou_cnt), 32'h1);
		check("fetch enable", 32'(fen), 32'h1);
		wr(A_CTL, 32'h0);
		// Preload cleared, then reloaded once FIFO has data
		wr(A_CTL, 32'h10);
		rd_chk("unloaded", A_ST, S_IDLE);
		ff <= 1'b1;
		@(posedge clk);
		check("reload req", 32'(preq), 32'h1);
		repeat (10) @(posedge clk);
		rd_chk("reloaded", A_ST, S_IDLE | S_PRLD);
		ff <= 1'b0;
		u_far.ack_dly = 0;
		// Normal runs on the selected clock
		r1 <= 1'b1;
		run_chk("start no enable", 32'h08, 0);
		run_chk("normal clk1", 32'h09, 3);
		rd_chk("prld dropped", A_ST, S_IDLE);
		check("irq masked", 32'(irq), 32'h0);
		wr(A_MSK, 32'h7);
		check("irq raised", 32'(irq), 32'h1);
		rd_chk("irq run end", A_IRQ, 32'h4);
		check("irq cleared", 32'(irq), 32'h0);
		run_chk("clk2 stopped", 32'h29, 0);
		pulses = 0;
		r2 <= 1'b1;
		repeat (80) @(posedge clk);
		check("clk2 runs", 32'(pulses), 32'h3);
		r2 <= 1'b0;
		// Frame mode waits for a trigger
		run_len = 16'h0002;
		run_chk("frame idle", 32'h05, 0);
		run_chk("frame start", 32'h0D, 0);
		pulses = 0;
		u_far.fire(5'h10);
		repeat (80) @(posedge clk);
		check("frame trig", 32'(pulses), 32'h2);
		wr(A_CTL, 32'h07);
		rd_chk("regs kept", A_CTL, 32'h05);
		wr(A_CTL, 32'h0);
		apb(1'b0, A_IRQ, 32'h0);
		// Fetch engine states
		wr(A_CTL, 32'h0001_0000);
		u_far.fire(5'h01);
		rd_chk("busy", A_ST, S_BUSY);
		u_far.fire(5'h06);
		rd_chk("done", A_ST, S_IDLE | S_DONE);
		rd_chk("irq done", A_IRQ, 32'h1);
		wr(A_BUF, 32'h100);
		rd_chk("validated", A_ST, S_IDLE);
		u_far.fire(5'h01);
		u_far.fire(5'h08);
		rd_chk("error", A_ST, S_ERR);
		check("run stopped", 32'(fok), 32'h0);
		u_far.fire(5'h01);
		rd_chk("stays error", A_ST, S_ERR);
		rd_chk("irq error", A_IRQ, 32'h2);
		wr(A_CTL, 32'h0);
		rd_chk("error cleared", A_ST, S_IDLE);
		wr(A_CTL, 32'h0001_0000);
		u_far.fire(5'h01);
		wr(A_CTL, 32'h0);
		rd_chk("finishes xfer", A_ST, S_BUSY);
		u_far.fire(5'h02);
		rd_chk("then idle", A_ST, S_IDLE);
		tally_and_finish;
	end
endmodule
